// ---- rtl/i2c_ctrl_regs.sv ----
// Two-wire bus slave with its control register, status, receive byte and
// interrupt logic, reached over APB. Assumes open-drain pads outside that
// resolve scl/sda from the enables, and a chip idle level on device_idle.
//
// Overview of operation
// - Stop seen with stop interrupt enabled sets a stop interrupt flag.
// - Start or repeated start seen with start enable sets a start flag.
// - Overwrite on loads byte unless full; off loads only while no overflow.
// - Data line changes 300 ns or 100 ns after each falling clock edge.
// - Collision interrupt only when slave collision detect enable is set.
// - Matching address with address hold: clear clock release, hold clock low.
// - Data byte with data hold: clear clock release, hold clock low.
// - Module enable takes over both bus pins; clear hands them back.
// - Stop-in-idle halts the module while the chip is idle.
// - Unimplemented control bits read as zero.
// - Sequence bits self-clear; clock release resets to one, hardware may clear.
`timescale 1ns/1ps
`default_nettype none

module i2c_ctrl_regs (
    input wire logic clk, // 125 MHz clock
    input wire logic arst_n, // Async reset
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB write
    input wire logic [7:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // Unmapped address
    input wire logic scl_in, // Clock pin level
    output logic scl_out, // Clock pin drive value
    output logic scl_oe, // Clock pin pull low
    input wire logic sda_in, // Data pin level
    output logic sda_out, // Data pin drive value
    output logic sda_oe, // Data pin pull low
    input wire logic device_idle, // Chip idle mode
    output logic pins_owned, // Pins taken from port
    output logic irq // Interrupt level
);

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] off);
        reg_hit = (a == off);
    endfunction : reg_hit

    i2c_ctrl_pkg::ctrl_type ctrl, next_ctrl;
    i2c_ctrl_pkg::slave_state_type state, next_state;
    logic scl_meta, scl_sync, scl_prev, sda_meta, sda_sync, sda_prev;
    logic [3:0] bit_cnt, next_bit_cnt;
    logic [7:0] shreg, rcv;
    logic [6:0] own_addr;
    logic [5:0] hold_cnt, next_hold_cnt;
    logic ack_on, rx_full, rx_ovf;
    logic [i2c_ctrl_pkg::IRQ_W-1:0] irq_stat, irq_mask, next_irq_stat;

    ////////////////////////////////////////////////////////////////////////////
    // Pins are asynchronous; two flops before any logic, idle bus is high
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            {scl_prev, scl_sync, scl_meta} <= 3'h7;
            {sda_prev, sda_sync, sda_meta} <= 3'h7;
        end else begin
            {scl_prev, scl_sync, scl_meta} <= {scl_sync, scl_meta, scl_in};
            {sda_prev, sda_sync, sda_meta} <= {sda_sync, sda_meta, sda_in};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    wire logic run = ctrl.module_enable & ~(ctrl.stop_in_idle & device_idle);
    wire logic scl_rise = scl_sync & ~scl_prev;
    wire logic scl_fall = ~scl_sync & scl_prev;
    wire logic bus_high = scl_sync & scl_prev;
    wire logic start_det = run & bus_high & sda_prev & ~sda_sync;
    wire logic stop_det = run & bus_high & ~sda_prev & sda_sync;
    wire logic active = (state == i2c_ctrl_pkg::st_addr) || (state == i2c_ctrl_pkg::st_data);
    wire logic in_data = state == i2c_ctrl_pkg::st_data;
    wire logic byte_done = scl_fall && bit_cnt == 4'h8 && active;
    wire logic ack_bit_end = scl_fall && bit_cnt == 4'h9;
    wire logic gen_call = ctrl.general_call_enable && shreg[7:1] == 7'h00;
    wire logic addr_match = ~shreg[0] && (shreg[7:1] == own_addr || gen_call);
    wire logic addr_hit = byte_done && !in_data && addr_match;
    // Overwrite mode ignores the overflow flag but never clobbers a full buffer
    wire logic load_ok = ctrl.buffer_overwrite_enable ? ~rx_full : ~rx_ovf;
    wire logic rx_load = byte_done && in_data && load_ok;
    wire logic hold_addr = addr_hit && ctrl.address_hold_enable;
    wire logic hold_data = byte_done && in_data && ctrl.data_hold_enable;
    // A start or stop inside a byte means another party fought the bus; a proper one follows one counted rise
    wire logic collision = (start_det | stop_det) && active && bit_cnt > 4'h1;

    ////////////////////////////////////////////////////////////////////////////
    // APB: one wait state, so reads and writes finish on the second access cycle
    wire logic access = psel & penable & ~pready;
    wire logic done = psel & penable & pready;
    wire logic wr = done & pwrite;
    wire logic rd = done & ~pwrite;
    wire logic wr_ctrl = wr & reg_hit(paddr, i2c_ctrl_pkg::OFF_CTRL);
    wire logic wr_stat = wr & reg_hit(paddr, i2c_ctrl_pkg::OFF_STAT);
    wire logic wr_addr = wr & reg_hit(paddr, i2c_ctrl_pkg::OFF_ADDR);
    wire logic wr_istat = wr & reg_hit(paddr, i2c_ctrl_pkg::OFF_IRQ_STAT);
    wire logic wr_imask = wr & reg_hit(paddr, i2c_ctrl_pkg::OFF_IRQ_MASK);
    wire logic rd_rcv = rd & reg_hit(paddr, i2c_ctrl_pkg::OFF_RCV);
    wire logic hit = reg_hit(paddr, i2c_ctrl_pkg::OFF_CTRL) | reg_hit(paddr, i2c_ctrl_pkg::OFF_STAT)
        | reg_hit(paddr, i2c_ctrl_pkg::OFF_RCV) | reg_hit(paddr, i2c_ctrl_pkg::OFF_ADDR)
        | reg_hit(paddr, i2c_ctrl_pkg::OFF_IRQ_STAT) | reg_hit(paddr, i2c_ctrl_pkg::OFF_IRQ_MASK);
    wire logic [31:0] stat_word = {25'h0, rx_ovf, 3'h0, rx_full, 1'h0, in_data};
    wire logic [31:0] rdata =
        reg_hit(paddr, i2c_ctrl_pkg::OFF_CTRL) ? 32'(ctrl) :
        reg_hit(paddr, i2c_ctrl_pkg::OFF_STAT) ? stat_word :
        reg_hit(paddr, i2c_ctrl_pkg::OFF_RCV) ? {24'h0, rcv} :
        reg_hit(paddr, i2c_ctrl_pkg::OFF_ADDR) ? {25'h0, own_addr} :
        reg_hit(paddr, i2c_ctrl_pkg::OFF_IRQ_STAT) ? {28'h0, irq_stat} :
        reg_hit(paddr, i2c_ctrl_pkg::OFF_IRQ_MASK) ? {28'h0, irq_mask} : 32'h0;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pready <= 1'h0;
            pslverr <= 1'h0;
            prdata <= 32'h0;
        end else begin
            pready <= access;
            pslverr <= access & ~hit;
            if (access)
                prdata <= rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // No master engine sits behind the sequence bits, so each completes at once
    always_comb begin
        next_ctrl = i2c_ctrl_pkg::ctrl_type'(32'(ctrl) & ~i2c_ctrl_pkg::GO_MASK);
        if (hold_addr || hold_data)
            next_ctrl.clock_release = 1'h0;
        if (wr_ctrl)
            next_ctrl = i2c_ctrl_pkg::ctrl_type'(pwdata & i2c_ctrl_pkg::CTRL_WMASK);
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl <= i2c_ctrl_pkg::ctrl_type'(i2c_ctrl_pkg::CTRL_RESET);
            own_addr <= i2c_ctrl_pkg::ADDR_RESET;
            irq_mask <= 4'h0;
        end else begin
            ctrl <= next_ctrl;
            if (wr_addr)
                own_addr <= pwdata[6:0];
            if (wr_imask)
                irq_mask <= pwdata[i2c_ctrl_pkg::IRQ_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_state = state;
        unique case (state)
            i2c_ctrl_pkg::st_idle: ;
            i2c_ctrl_pkg::st_addr: begin
                if (byte_done && !addr_match)
                    next_state = i2c_ctrl_pkg::st_ignore;
                else if (ack_bit_end)
                    next_state = i2c_ctrl_pkg::st_data;
            end
            i2c_ctrl_pkg::st_data: ;
            i2c_ctrl_pkg::st_ignore: ;
        endcase
        if (start_det)
            next_state = i2c_ctrl_pkg::st_addr;
        if (stop_det || !run)
            next_state = i2c_ctrl_pkg::st_idle;
    end

    always_comb begin
        next_bit_cnt = bit_cnt;
        if (!run || start_det || state == i2c_ctrl_pkg::st_idle || ack_bit_end)
            next_bit_cnt = 4'h0;
        else if (scl_rise && bit_cnt != 4'h9)
            next_bit_cnt = 4'(bit_cnt + 4'h1);
    end

    // Hold time counts from the detected fall, so the pin sees a little more
    always_comb begin
        next_hold_cnt = (hold_cnt != 6'h0) ? 6'(hold_cnt - 6'h1) : 6'h0;
        if (scl_fall)
            next_hold_cnt = ctrl.data_hold_time_select ? i2c_ctrl_pkg::HOLD_LONG_CYC
                : i2c_ctrl_pkg::HOLD_SHORT_CYC;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= i2c_ctrl_pkg::st_idle;
            bit_cnt <= 4'h0;
            shreg <= 8'h00;
            hold_cnt <= 6'h0;
            ack_on <= 1'h0;
        end else begin
            state <= next_state;
            bit_cnt <= next_bit_cnt;
            hold_cnt <= next_hold_cnt;
            if (scl_rise && bit_cnt < 4'h8)
                shreg <= {shreg[6:0], sda_sync};
            if (!run || start_det || stop_det || ack_bit_end)
                ack_on <= 1'h0;
            else if (addr_hit || rx_load)
                ack_on <= 1'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Set wins over clear for the full and overflow flags
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rx_full <= 1'h0;
            rx_ovf <= 1'h0;
            rcv <= 8'h00;
        end else begin
            if (rx_load)
                rcv <= shreg;
            if (rx_load)
                rx_full <= 1'h1;
            else if (rd_rcv)
                rx_full <= 1'h0;
            if (byte_done && in_data && rx_full)
                rx_ovf <= 1'h1;
            else if (wr_stat && pwdata[i2c_ctrl_pkg::STAT_OVF])
                rx_ovf <= 1'h0;
        end
    end

    wire logic [i2c_ctrl_pkg::IRQ_W-1:0] irq_evt = {
        collision & ctrl.slave_collision_detect_enable,
        rx_load,
        stop_det & ctrl.stop_irq_enable,
        start_det & ctrl.start_irq_enable};
    wire logic [i2c_ctrl_pkg::IRQ_W-1:0] irq_clr = wr_istat ? pwdata[i2c_ctrl_pkg::IRQ_W-1:0] : 4'h0;
    assign next_irq_stat = (irq_stat & ~irq_clr) | irq_evt;

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_stat <= 4'h0;
            irq <= 1'h0;
            pins_owned <= 1'h0;
            scl_oe <= 1'h0;
            sda_oe <= 1'h0;
            scl_out <= 1'h0;
            sda_out <= 1'h0;
        end else begin
            irq_stat <= next_irq_stat;
            irq <= |(next_irq_stat & irq_mask);
            pins_owned <= ctrl.module_enable;
            scl_out <= 1'h0;
            sda_out <= 1'h0;
            scl_oe <= run && active && !ctrl.clock_release;
            if (!run || state == i2c_ctrl_pkg::st_idle)
                sda_oe <= 1'h0;
            else if (hold_cnt == 6'h1)
                sda_oe <= ack_on;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    property p_stop_irq;
        stop_det && ctrl.stop_irq_enable |=> irq_stat[i2c_ctrl_pkg::IRQ_STOP];
    endproperty
    a_stop_irq: assert property (p_stop_irq) else $error("stop flag not set");

    property p_start_quiet;
        !ctrl.start_irq_enable && !irq_stat[i2c_ctrl_pkg::IRQ_START] |=> !irq_stat[i2c_ctrl_pkg::IRQ_START];
    endproperty
    a_start_quiet: assert property (p_start_quiet) else $error("start flag set while off");

    property p_start_irq;
        start_det && ctrl.start_irq_enable |=> irq_stat[i2c_ctrl_pkg::IRQ_START] && state == i2c_ctrl_pkg::st_addr;
    endproperty
    a_start_irq: assert property (p_start_irq) else $error("start not taken");

    property p_rx_load;
        rx_load |=> rx_full && rcv == $past(shreg) ##1 1'h1;
    endproperty
    a_rx_load: assert property (p_rx_load) else $error("byte not loaded");

    property p_no_overwrite;
        byte_done && in_data && !ctrl.buffer_overwrite_enable && rx_ovf |=> $stable(rcv);
    endproperty
    a_no_overwrite: assert property (p_no_overwrite) else $error("overflowed byte loaded");

    property p_hold_load;
        scl_fall |=> hold_cnt == ($past(ctrl.data_hold_time_select) ? i2c_ctrl_pkg::HOLD_LONG_CYC
            : i2c_ctrl_pkg::HOLD_SHORT_CYC);
    endproperty
    a_hold_load: assert property (p_hold_load) else $error("wrong hold count");

    property p_sda_moment;
        $changed(sda_oe) |-> $past(hold_cnt) == 6'h1 || !$past(run) || $past(state) == i2c_ctrl_pkg::st_idle;
    endproperty
    a_sda_moment: assert property (p_sda_moment) else $error("data moved inside hold");

    property p_coll;
        collision && ctrl.slave_collision_detect_enable |=> irq_stat[i2c_ctrl_pkg::IRQ_COLL];
    endproperty
    a_coll: assert property (p_coll) else $error("collision flag missing");

    property p_addr_hold;
        hold_addr && !wr_ctrl |=> !ctrl.clock_release ##1 scl_oe;
    endproperty
    a_addr_hold: assert property (p_addr_hold) else $error("no address stretch");

    property p_data_hold;
        hold_data && !wr_ctrl |=> !ctrl.clock_release ##1 scl_oe;
    endproperty
    a_data_hold: assert property (p_data_hold) else $error("no data stretch");

    property p_pins;
        !ctrl.module_enable |=> !pins_owned && !sda_oe && !scl_oe;
    endproperty
    a_pins: assert property (p_pins) else $error("pins driven while off");

    property p_idle;
        ctrl.stop_in_idle && device_idle |=> state == i2c_ctrl_pkg::st_idle;
    endproperty
    a_idle: assert property (p_idle) else $error("ran in idle");

    property p_zero;
        pready && !pwrite && paddr == i2c_ctrl_pkg::OFF_CTRL |-> prdata[31:23] == 9'h0 && !prdata[14];
    endproperty
    a_zero: assert property (p_zero) else $error("reserved bit reads one");

    property p_go;
        (32'(ctrl) & i2c_ctrl_pkg::GO_MASK) != 32'h0 && !wr_ctrl |=> (32'(ctrl) & i2c_ctrl_pkg::GO_MASK) == 32'h0;
    endproperty
    a_go: assert property (p_go) else $error("sequence bit stuck");

    c_addr: cover property (addr_hit);
    c_stretch: cover property (scl_oe ##1 !scl_oe);
    c_rx: cover property (rx_load);
    c_ovf: cover property (byte_done && in_data && rx_full);

endmodule : i2c_ctrl_regs

`default_nettype wire

// ---- rtl/i2c_ctrl_pkg.sv ----
// Constants, register layout and types of the two-wire slave control block.
// Assumes a 125 MHz peripheral clock and an APB register port of 32-bit words.
package i2c_ctrl_pkg;

    ////////////////////////////////////////////////////////////////////////////
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STAT = 8'h04;
    localparam logic [7:0] OFF_RCV = 8'h08;
    localparam logic [7:0] OFF_ADDR = 8'h0C;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h10;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h14;

    localparam logic [31:0] CTRL_RESET = 32'h0000_1000;
    localparam logic [31:0] CTRL_WMASK = 32'h007F_BFFF;
    localparam logic [31:0] GO_MASK = 32'h0000_001F;
    localparam logic [6:0] ADDR_RESET = 7'h2A;

    localparam int STAT_ADDRESSED = 0;
    localparam int STAT_FULL = 2;
    localparam int STAT_OVF = 6;

    localparam int IRQ_START = 0;
    localparam int IRQ_STOP = 1;
    localparam int IRQ_RX = 2;
    localparam int IRQ_COLL = 3;
    localparam int IRQ_W = 4;

    ////////////////////////////////////////////////////////////////////////////
    localparam int CLK_PERIOD_NS = 8;
    localparam int HOLD_SHORT_NS = 100;
    localparam int HOLD_LONG_NS = 300;
    localparam logic [5:0] HOLD_SHORT_CYC = 6'((HOLD_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [5:0] HOLD_LONG_CYC = 6'((HOLD_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    ////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [8:0] zero_hi;
        logic stop_irq_enable;
        logic start_irq_enable;
        logic buffer_overwrite_enable;
        logic data_hold_time_select;
        logic slave_collision_detect_enable;
        logic address_hold_enable;
        logic data_hold_enable;
        logic module_enable;
        logic zero_14;
        logic stop_in_idle;
        logic clock_release;
        logic address_rules_a;
        logic ten_bit_address_mode;
        logic slew_control_disable;
        logic smbus_levels_enable;
        logic general_call_enable;
        logic clock_stretch_enable;
        logic ack_value;
        logic ack_sequence_go;
        logic receive_go;
        logic stop_go;
        logic restart_go;
        logic start_go;
    } ctrl_type;

    typedef enum {st_idle, st_addr, st_data, st_ignore} slave_state_type;

endpackage : i2c_ctrl_pkg

// ---- sim/i2c_bus_master_model.sv ----
// Behavioural two-wire bus master that drives the slave under test.
// Assumes open-drain wires with pull-ups resolved by the bench.
`timescale 1ns/1ps
`default_nettype none

module i2c_bus_master_model (
    input wire logic clk, // Pacing clock
    input wire logic scl_line, // Resolved clock wire
    input wire logic sda_line, // Resolved data wire
    output var logic scl_low, // Pulls clock low
    output var logic sda_low // Pulls data low
);
    ////////////////////////////////////////////////////////////
    int hold_cyc;
    int stalls;

    initial begin
        scl_low = 1'b0;
        sda_low = 1'b0;
        hold_cyc = 0;
        stalls = 0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick

    // A stretching slave keeps the wire low, so high time counts from release
    task automatic rise();
        int k;
        scl_low <= 1'b0;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (!scl_line && k < 400);
        if (!scl_line)
            stalls++;
        tick(4);
    endtask : rise

    task automatic start();
        @(posedge clk);
        sda_low <= 1'b1;
        tick(5);
        scl_low <= 1'b1;
    endtask : start

    task automatic stop();
        @(posedge clk);
        sda_low <= 1'b1;
        tick(5);
        rise();
        sda_low <= 1'b0;
        tick(5);
    endtask : stop

    task automatic bit_out(input logic b);
        @(posedge clk);
        sda_low <= !b;
        tick(4);
        rise();
        scl_low <= 1'b1;
    endtask : bit_out

    // Long low phase around the ack bit leaves room for a 300 ns slave hold
    task automatic byte_out(input logic [7:0] d, output logic ack);
        int k;
        for (int i = 7; i >= 0; i--) begin
            bit_out(d[i]);
        end
        sda_low <= 1'b0;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (sda_line && k < 60);
        hold_cyc = k;
        tick(60 - k);
        rise();
        ack = sda_line;
        @(posedge clk);
        scl_low <= 1'b1;
        tick(50);
    endtask : byte_out

endmodule : i2c_bus_master_model
`default_nettype wire

// ---- sim/i2c_control_register_logic_test.sv ----
// Self-checking bench for the two-wire slave control block over APB.
// Assumes the bus master model file and pull-ups on both wires.
`timescale 1ns/1ps
`default_nettype none

module i2c_control_register_logic_test;
    ////////////////////////////////////////////////////////////
    localparam logic [31:0] EN = 32'h0000_9000;
    // Own address in the top seven bits, write direction
    localparam logic [7:0] ADR = {i2c_ctrl_pkg::ADDR_RESET, 1'b0};
    logic clk, arst_n, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic scl_oe, sda_oe, device_idle, pins_owned, irq, m_scl, m_sda, scl_do, sda_do;
    wire logic scl_w, sda_w;
    int fails = 0;
    int num_checks = 0;

    assign scl_w = !(scl_oe | m_scl);
    assign sda_w = !(sda_oe | m_sda);

    i2c_ctrl_regs dut (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .scl_in(scl_w), .scl_out(scl_do), .scl_oe(scl_oe), .sda_in(sda_w), .sda_out(sda_do), .sda_oe(sda_oe),
        .device_idle(device_idle), .pins_owned(pins_owned), .irq(irq));
    i2c_bus_master_model m (.clk(clk), .scl_line(scl_w), .sda_line(sda_w), .scl_low(m_scl), .sda_low(m_sda));

    initial begin
        clk = 1'b0;
        forever #4 clk = !clk;
    end

    task automatic conclude();
        $display("Checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : conclude

    task automatic give_up();
        fails++;
        $display("MISMATCH %0t wait ran out", $time);
        conclude();
    endtask : give_up

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) give_up();
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] mask);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0000_0000, r, e);
        chk(r & mask, exp);
    endtask : rd_chk

    task automatic send(input logic [7:0] b, input logic ack_exp, input int hold_ns);
        logic a;
        m.byte_out(b, a);
        if (m.stalls != 0) give_up();
        chk(a, ack_exp);
        if (!ack_exp) begin
            chk(m.hold_cyc * 8 >= hold_ns && m.hold_cyc * 8 <= hold_ns + 80, 1'b1);
        end
    endtask : send

    task automatic wait_oe(input logic v);
        int n;
        n = 0;
        while (scl_oe !== v && n < 2000) begin
            @(posedge clk);
            n++;
        end
        if (scl_oe !== v) give_up();
    endtask : wait_oe

    initial begin
        logic [31:0] r;
        logic e;
        arst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        device_idle = 1'b0;
        repeat (20) @(posedge clk);
        arst_n <= 1'b1;
        rd_chk(i2c_ctrl_pkg::OFF_CTRL, i2c_ctrl_pkg::CTRL_RESET, '1);
        chk(pins_owned, 1'b0);
        wr(i2c_ctrl_pkg::OFF_CTRL, '1);
        repeat (2) @(posedge clk);
        chk(pins_owned, 1'b1);
        rd_chk(i2c_ctrl_pkg::OFF_CTRL, 32'h007F_BFE0, '1);
        apb(1'b0, 8'h40, 32'h0000_0000, r, e);
        chk(e, 1'b1);
        chk(r, 32'h0000_0000);
        wr(i2c_ctrl_pkg::OFF_CTRL, 32'h0000_1000);
        repeat (2) @(posedge clk);
        chk(pins_owned, 1'b0);
        wr(i2c_ctrl_pkg::OFF_IRQ_MASK, 32'h0000_000F);
        for (int i = 0; i < 2; i++) begin
            wr(i2c_ctrl_pkg::OFF_CTRL, i ? EN | 32'h0060_0000 : EN | 32'h0008_0000);
            m.start();
            send(ADR, 1'b0, i ? 100 : 300);
            send(8'hA5 ^ 8'(i), 1'b0, i ? 100 : 300);
            m.stop();
            rd_chk(i2c_ctrl_pkg::OFF_IRQ_STAT, i ? 7 : 4, 32'h0000_000F);
            chk(irq, 1'b1);
            rd_chk(i2c_ctrl_pkg::OFF_RCV, 8'hA5 ^ 8'(i), 32'h0000_00FF);
            wr(i2c_ctrl_pkg::OFF_IRQ_STAT, 32'h0000_000F);
        end
        wr(i2c_ctrl_pkg::OFF_IRQ_MASK, 32'h0000_0000);
        wr(i2c_ctrl_pkg::OFF_CTRL, EN);
        m.start();
        send(ADR, 1'b0, 100);
        send(8'h11, 1'b0, 100);
        send(8'h22, 1'b0, 100);
        send(8'h33, 1'b1, 100);
        m.stop();
        chk(irq, 1'b0);
        rd_chk(i2c_ctrl_pkg::OFF_RCV, 8'h22, 32'h0000_00FF);
        rd_chk(i2c_ctrl_pkg::OFF_STAT, 32'h0000_0040, 32'h0000_0044);
        wr(i2c_ctrl_pkg::OFF_IRQ_MASK, 32'h0000_000F);
        repeat (2) @(posedge clk);
        chk(irq, 1'b1);
        wr(i2c_ctrl_pkg::OFF_CTRL, EN | 32'h0010_0000);
        m.start();
        send(ADR, 1'b0, 100);
        send(8'h44, 1'b0, 100);
        m.stop();
        rd_chk(i2c_ctrl_pkg::OFF_RCV, 8'h44, 32'h0000_00FF);
        wr(i2c_ctrl_pkg::OFF_STAT, 32'h0000_0040);
        wr(i2c_ctrl_pkg::OFF_IRQ_STAT, 32'h0000_000F);
        repeat (2) @(posedge clk);
        chk(irq, 1'b0);
        wr(i2c_ctrl_pkg::OFF_CTRL, EN | 32'h0003_0000);
        fork
            begin
                m.start();
                send(ADR, 1'b0, 100);
                send(8'hC3, 1'b0, 100);
                m.stop();
            end
            repeat (2) begin
                wait_oe(1'b1);
                rd_chk(i2c_ctrl_pkg::OFF_CTRL, 32'h0000_0000, 32'h0000_1000);
                repeat (8) @(posedge clk);
                chk(scl_oe, 1'b1);
                wr(i2c_ctrl_pkg::OFF_CTRL, EN | 32'h0003_0000);
                wait_oe(1'b0);
            end
        join
        rd_chk(i2c_ctrl_pkg::OFF_RCV, 8'hC3, 32'h0000_00FF);
        // Halted in idle, then running, then idle without the halt bit
        for (int i = 0; i < 3; i++) begin
            wr(i2c_ctrl_pkg::OFF_CTRL, (i == 2) ? EN : EN | 32'h0004_2000);
            device_idle <= (i != 1);
            m.start();
            send(ADR, i == 0, 100);
            m.stop();
        end
        device_idle <= 1'b0;
        // A clean stop right after an address must not count as a collision
        rd_chk(i2c_ctrl_pkg::OFF_IRQ_STAT, 0, 32'h0000_0008);
        for (int i = 0; i < 2; i++) begin
            wr(i2c_ctrl_pkg::OFF_CTRL, i ? EN | 32'h0004_0000 : EN | 32'h0000_0080);
            wr(i2c_ctrl_pkg::OFF_IRQ_STAT, 32'h0000_000F);
            m.start();
            send(i ? ADR : 8'h00, 1'b0, 100);
            repeat (4) m.bit_out(1'b1);
            m.stop();
            rd_chk(i2c_ctrl_pkg::OFF_IRQ_STAT, i ? 8 : 0, 32'h0000_0008);
        end
        chk(sda_oe, 1'b0);
        chk({scl_do, sda_do}, 2'h0);
        chk(m.stalls, 0);
        conclude();
    end

endmodule : i2c_control_register_logic_test
`default_nettype wire
